// >>> src/dctl_host.sv
`default_nettype none
`include "dctl_defs.svh"

module dctl_host #(
  parameter int CS_COUNT = 4
) (
  input wire logic mclk, // 20 MHz system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // slave address
  input wire logic [1:0] htrans, // slave transfer type
  input wire logic hwrite, // slave direction
  input wire logic [2:0] hsize, // slave size, word only
  input wire logic [31:0] hwdata, // slave write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave never stalls
  output logic hresp, // always okay
  output logic [31:0] hrdata, // slave read data
  output logic irq, // level, unmasked event pending
  output logic [31:0] mHaddr, // device bus address
  output logic [1:0] mHtrans, // device bus transfer type
  output logic mHwrite, // device bus direction
  output logic [2:0] mHsize, // device bus size
  output logic [31:0] mHwdata, // device bus write data
  input wire logic mHready, // device bus ready
  input wire logic [31:0] mHrdata, // device bus read data
  input wire logic mHresp // device bus response, ignored
);

  if (CS_COUNT < 1 || CS_COUNT > 4) begin : g_bad
    $error("dctl_host: CS_COUNT out of range");
  end

  // idx and diffCount are four bits, so the word list must stay below sixteen
  if (`DCTL_SNAP_WORDS > 15) begin : g_bad_snap
    $error("dctl_host: snapshot list too long");
  end

  // the tiers must fill exactly the thirty data bits of each wake register
  if (`DCTL_TIERS * `DCTL_TIER_W != 30) begin : g_bad_wake
    $error("dctl_host: wake tiers do not fit the register");
  end

  // -----------------------------------------------------------------
  // address helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] ctlAddr(input logic [11:0] idx);
    return `DCTL_CTL_BASE + {18'h0, idx, 2'h0};
  endfunction : ctlAddr

  // ten consecutive fail/expected words, then the error count
  function automatic logic [31:0] snapAddr(input logic [3:0] i);
    logic [11:0] idx;
    idx = (i == 4'(`DCTL_SNAP_WORDS - 1)) ? `DCTL_SNAP_ERRCNT_IDX
                                           : `DCTL_SNAP_FIRST_IDX + {8'h0, i};
    return ctlAddr(idx);
  endfunction : snapAddr

  function automatic logic [31:0] mr13Addr(input logic [3:0] cs);
    logic [11:0] idx;
    idx = `DCTL_TRAIN_MR13_IDX0 + 12'(cs * `DCTL_TRAIN_MR13_STEP);
    return `DCTL_PI_BASE + {18'h0, idx, 2'h0};
  endfunction : mr13Addr

  // -----------------------------------------------------------------
  // state and submodules
  // -----------------------------------------------------------------
  dctl_pkg::dctl_host_type r_reg, r_next;

  logic mReq;
  logic [31:0] mReqAddr;
  logic mReqWrite;
  logic [31:0] mReqData;
  logic mDone;
  logic [31:0] mRdata;
  logic [`DCTL_TIERS-1:0] enFilled;
  logic orderOk;

  dctl_ahb_mst u_mst (
    .mclk(mclk),
    .resetn(resetn),
    .req(mReq),
    .reqAddr(mReqAddr),
    .reqWrite(mReqWrite),
    .reqData(mReqData),
    .done(mDone),
    .rdata(mRdata),
    .mHaddr(mHaddr),
    .mHtrans(mHtrans),
    .mHwrite(mHwrite),
    .mHsize(mHsize),
    .mHwdata(mHwdata),
    .mHready(mHready),
    .mHrdata(mHrdata)
  );

  dctl_wake_check #(
    .FSP_COUNT(`DCTL_FSPS)
  ) u_wake (
    .enReq(r_reg.lpEnable),
    .wake(r_reg.wake),
    .enFilled(enFilled),
    .orderOk(orderOk)
  );

  logic [`DCTL_EVENTS-1:0] ev;
  logic opActive;
  logic [5:0] rdIdx;
  logic [31:0] rdVal;

  always_comb begin
    r_next = r_reg;
    ev = '0;
    opActive = 1'b0;
    mReqAddr = 32'h0000_0000;
    mReqWrite = 1'b0;
    mReqData = 32'h0000_0000;
    rdIdx = haddr[7:2];
    rdVal = 32'h0000_0000;

    // ---------------------------------------------------------------
    // slave: address phase captured, write applied in data phase
    // ---------------------------------------------------------------
    case (rdIdx)
      `DCTL_REG_STATUS: rdVal = {22'h0, r_reg.diffCount, r_reg.lastPass,
                                 r_reg.state != dctl_pkg::ST_IDLE, r_reg.state};
      `DCTL_REG_IRQ_STAT: rdVal = {27'h0, r_reg.irqStat};
      `DCTL_REG_IRQ_MASK: rdVal = {27'h0, r_reg.irqMask};
      `DCTL_REG_LP_EN: rdVal = {27'h0, r_reg.lpEnable};
      `DCTL_REG_WAKE_F0: rdVal = {2'h0, r_reg.wake[0]};
      `DCTL_REG_WAKE_F0 + 6'h01: rdVal = {2'h0, r_reg.wake[1]};
      `DCTL_REG_WAKE_F0 + 6'h02: rdVal = {2'h0, r_reg.wake[2]};
      `DCTL_REG_BIST_CTL: rdVal = r_reg.bistCtl;
      default: rdVal = 32'h0000_0000;
    endcase
    if (hready) begin
      r_next.aValid = hsel & htrans[1];
      r_next.aWrite = hwrite;
      r_next.aAddr = haddr[7:2];
      if (hsel && htrans[1] && !hwrite) begin
        r_next.hrdata = rdVal;
      end
    end
    if (r_reg.aValid && r_reg.aWrite) begin
      case (r_reg.aAddr)
        `DCTL_REG_CMD: begin
          // commands while busy are dropped; status shows busy
          if (r_reg.state == dctl_pkg::ST_IDLE) begin
            r_next.idx = 4'h0;
            r_next.diffCount = 4'h0;
            if (hwdata[`DCTL_CMD_BIST]) begin
              r_next.state = dctl_pkg::ST_BSNAP;
            end else if (hwdata[`DCTL_CMD_LOWPOWER]) begin
              r_next.state = dctl_pkg::ST_LPCHK;
            end else if (hwdata[`DCTL_CMD_TRAIN]) begin
              r_next.state = dctl_pkg::ST_TRRD;
            end
          end
        end
        `DCTL_REG_IRQ_STAT: r_next.irqStat = r_reg.irqStat & ~hwdata[`DCTL_EVENTS-1:0];
        `DCTL_REG_IRQ_MASK: r_next.irqMask = hwdata[`DCTL_EVENTS-1:0];
        `DCTL_REG_LP_EN: r_next.lpEnable = hwdata[`DCTL_TIERS-1:0];
        `DCTL_REG_WAKE_F0: r_next.wake[0] = hwdata[29:0];
        `DCTL_REG_WAKE_F0 + 6'h01: r_next.wake[1] = hwdata[29:0];
        `DCTL_REG_WAKE_F0 + 6'h02: r_next.wake[2] = hwdata[29:0];
        `DCTL_REG_BIST_CTL: r_next.bistCtl = hwdata;
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // sequencer: one device access in flight at a time, the next issued after done
    // ---------------------------------------------------------------
    case (r_reg.state)
      dctl_pkg::ST_IDLE: ;
      dctl_pkg::ST_BSNAP: begin
        opActive = 1'b1;
        mReqAddr = snapAddr(r_reg.idx);
        if (mDone) begin
          r_next.snap[r_reg.idx] = mRdata;
          r_next.idx = r_reg.idx + 4'h1;
          if (r_reg.idx == 4'(`DCTL_SNAP_WORDS - 1)) begin
            r_next.idx = 4'h0;
            r_next.state = dctl_pkg::ST_BGO;
          end
        end
      end
      dctl_pkg::ST_BGO: begin
        opActive = 1'b1;
        mReqAddr = ctlAddr(`DCTL_SELFTEST_CTRL_IDX);
        mReqWrite = 1'b1;
        mReqData = r_reg.bistCtl;
        mReqData[`DCTL_SELFTEST_GO_BIT] = 1'b1;
        if (mDone) begin
          r_next.state = dctl_pkg::ST_BPOLL;
        end
      end
      dctl_pkg::ST_BPOLL: begin
        opActive = 1'b1;
        mReqAddr = ctlAddr(`DCTL_IRQ_STATUS_IDX);
        if (mDone && mRdata[`DCTL_SELFTEST_DONE_BIT]) begin
          r_next.state = dctl_pkg::ST_BCHK;
        end
      end
      dctl_pkg::ST_BCHK: begin
        opActive = 1'b1;
        mReqAddr = snapAddr(r_reg.idx);
        if (mDone) begin
          // the device's own result field is ignored, it self-clears
          if (mRdata != r_reg.snap[r_reg.idx]) begin
            r_next.diffCount = r_reg.diffCount + 4'h1;
          end
          r_next.idx = r_reg.idx + 4'h1;
          if (r_reg.idx == 4'(`DCTL_SNAP_WORDS - 1)) begin
            r_next.idx = 4'h0;
            r_next.state = dctl_pkg::ST_BSTOP;
          end
        end
      end
      dctl_pkg::ST_BSTOP: begin
        opActive = 1'b1;
        mReqAddr = ctlAddr(`DCTL_SELFTEST_CTRL_IDX);
        mReqWrite = 1'b1;
        mReqData = r_reg.bistCtl;
        mReqData[`DCTL_SELFTEST_GO_BIT] = 1'b0;
        if (mDone) begin
          r_next.lastPass = (r_reg.diffCount == 4'h0);
          ev[`DCTL_EV_BIST_DONE] = 1'b1;
          ev[`DCTL_EV_BIST_FAIL] = (r_reg.diffCount != 4'h0);
          r_next.state = dctl_pkg::ST_IDLE;
        end
      end
      dctl_pkg::ST_LPCHK: begin
        // refuse rather than let the device shorten a wakeup time
        if (orderOk) begin
          r_next.state = dctl_pkg::ST_LPTIME;
        end else begin
          ev[`DCTL_EV_LP_REFUSED] = 1'b1;
          r_next.state = dctl_pkg::ST_IDLE;
        end
      end
      dctl_pkg::ST_LPTIME: begin
        opActive = 1'b1;
        mReqAddr = `DCTL_WAKE_BASE + {26'h0, r_reg.idx, 2'h0};
        mReqWrite = 1'b1;
        mReqData = {2'h0, r_reg.wake[r_reg.idx[1:0]]};
        if (mDone) begin
          r_next.idx = r_reg.idx + 4'h1;
          if (r_reg.idx == 4'(`DCTL_FSPS - 1)) begin
            r_next.state = dctl_pkg::ST_LPRD;
          end
        end
      end
      dctl_pkg::ST_LPRD: begin
        opActive = 1'b1;
        mReqAddr = ctlAddr(`DCTL_LOWPOWER_WAKE_IDX);
        if (mDone) begin
          r_next.scratch = mRdata;
          r_next.state = dctl_pkg::ST_LPWR;
        end
      end
      dctl_pkg::ST_LPWR: begin
        opActive = 1'b1;
        mReqAddr = ctlAddr(`DCTL_LOWPOWER_WAKE_IDX);
        mReqWrite = 1'b1;
        mReqData = r_reg.scratch;
        mReqData[`DCTL_WAKE_EN_MSB:`DCTL_WAKE_EN_LSB] = {1'b0, enFilled};
        if (mDone) begin
          ev[`DCTL_EV_LP_DONE] = 1'b1;
          r_next.state = dctl_pkg::ST_IDLE;
        end
      end
      dctl_pkg::ST_TRRD: begin
        opActive = 1'b1;
        mReqAddr = mr13Addr(r_reg.idx);
        if (mDone) begin
          r_next.scratch = mRdata;
          r_next.state = dctl_pkg::ST_TRWR;
        end
      end
      dctl_pkg::ST_TRWR: begin
        opActive = 1'b1;
        mReqAddr = mr13Addr(r_reg.idx);
        mReqWrite = 1'b1;
        mReqData = r_reg.scratch;
        // one image serves both command bus and write DQ training
        mReqData[`DCTL_MR13_VRCG_BIT] = 1'b1;
        if (mDone) begin
          r_next.idx = r_reg.idx + 4'h1;
          r_next.state = dctl_pkg::ST_TRRD;
          if (r_reg.idx == 4'(CS_COUNT - 1)) begin
            ev[`DCTL_EV_TRAIN_DONE] = 1'b1;
            r_next.state = dctl_pkg::ST_IDLE;
          end
        end
      end
      default: r_next.state = dctl_pkg::ST_IDLE;
    endcase

    mReq = opActive & ~r_reg.pend;
    if (mReq) begin
      r_next.pend = 1'b1;
    end else if (mDone) begin
      r_next.pend = 1'b0;
    end

    // set beats a same-cycle write-one clear
    r_next.irqStat = r_next.irqStat | ev;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r_reg.hrdata;
  assign irq = |(r_reg.irqStat & r_reg.irqMask);

endmodule : dctl_host

`default_nettype wire

// >>> src/dctl_defs.svh
`ifndef DCTL_DEFS_SVH
`define DCTL_DEFS_SVH

// ----------------------------------------------------------------
// device register map, word index times four from each base
// ----------------------------------------------------------------
`define DCTL_CTL_BASE 32'h0000_0000
`define DCTL_PI_BASE 32'h0000_2000
`define DCTL_WAKE_BASE 32'h0000_4000
`define DCTL_IRQ_STATUS_IDX 12'd293
`define DCTL_SELFTEST_CTRL_IDX 12'd194
`define DCTL_LOWPOWER_WAKE_IDX 12'd139
`define DCTL_SNAP_FIRST_IDX 12'd302
`define DCTL_SNAP_ERRCNT_IDX 12'd206
`define DCTL_TRAIN_MR13_IDX0 12'd259
`define DCTL_TRAIN_MR13_STEP 12'd2

// ----------------------------------------------------------------
// device field positions
// ----------------------------------------------------------------
`define DCTL_SELFTEST_DONE_BIT 11
`define DCTL_SELFTEST_GO_BIT 0
`define DCTL_WAKE_EN_LSB 24
`define DCTL_WAKE_EN_MSB 29
`define DCTL_MR13_VRCG_BIT 3

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define DCTL_SNAP_WORDS 11
`define DCTL_TIERS 5
`define DCTL_TIER_W 6
`define DCTL_FSPS 3
`define DCTL_EVENTS 5

// ----------------------------------------------------------------
// own register map (word index) and reset values
// ----------------------------------------------------------------
`define DCTL_REG_CMD 6'h00
`define DCTL_REG_STATUS 6'h01
`define DCTL_REG_IRQ_STAT 6'h02
`define DCTL_REG_IRQ_MASK 6'h03
`define DCTL_REG_LP_EN 6'h04
`define DCTL_REG_WAKE_F0 6'h05
`define DCTL_REG_BIST_CTL 6'h08
`define DCTL_CMD_BIST 0
`define DCTL_CMD_LOWPOWER 1
`define DCTL_CMD_TRAIN 2
`define DCTL_EV_BIST_DONE 0
`define DCTL_EV_BIST_FAIL 1
`define DCTL_EV_LP_DONE 2
`define DCTL_EV_LP_REFUSED 3
`define DCTL_EV_TRAIN_DONE 4
`define DCTL_RST_WORD 32'h0000_0000

`endif

// >>> src/dctl_pkg.sv
`default_nettype none
`include "dctl_defs.svh"

package dctl_pkg;

  typedef enum logic [1:0] {MST_IDLE, MST_ADDR, MST_DATA} dctl_mst_state_type;

  typedef struct packed {
    dctl_mst_state_type state;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] data;
    logic [31:0] rdata;
    logic done;
  } dctl_mst_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_BSNAP, ST_BGO, ST_BPOLL, ST_BCHK, ST_BSTOP,
    ST_LPCHK, ST_LPTIME, ST_LPRD, ST_LPWR, ST_TRRD, ST_TRWR
  } dctl_state_type;

  typedef struct packed {
    dctl_state_type state;
    logic pend;
    logic [3:0] idx;
    logic [`DCTL_SNAP_WORDS-1:0][31:0] snap;
    logic [31:0] scratch;
    logic [3:0] diffCount;
    logic lastPass;
    logic [`DCTL_EVENTS-1:0] irqStat;
    logic [`DCTL_EVENTS-1:0] irqMask;
    logic [`DCTL_TIERS-1:0] lpEnable;
    logic [`DCTL_FSPS-1:0][`DCTL_TIERS*`DCTL_TIER_W-1:0] wake;
    logic [31:0] bistCtl;
    logic aValid;
    logic aWrite;
    logic [5:0] aAddr;
    logic [31:0] hrdata;
  } dctl_host_type;

endpackage : dctl_pkg

`default_nettype wire

// >>> src/dctl_ahb_mst.sv
`default_nettype none
`include "dctl_defs.svh"

module dctl_ahb_mst (
  input wire logic mclk, // system clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic req, // start one single-word transfer
  input wire logic [31:0] reqAddr, // byte address
  input wire logic reqWrite, // 1 write, 0 read
  input wire logic [31:0] reqData, // write data
  output logic done, // one-cycle pulse, transfer finished
  output logic [31:0] rdata, // read data, valid with done
  output logic [31:0] mHaddr, // ahb address
  output logic [1:0] mHtrans, // ahb transfer type
  output logic mHwrite, // ahb direction
  output logic [2:0] mHsize, // always word
  output logic [31:0] mHwdata, // ahb write data
  input wire logic mHready, // ahb ready
  input wire logic [31:0] mHrdata // ahb read data
);

  dctl_pkg::dctl_mst_type r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    case (r_reg.state)
      dctl_pkg::MST_IDLE: begin
        if (req) begin
          r_next.haddr = reqAddr;
          r_next.hwrite = reqWrite;
          r_next.data = reqData;
          r_next.htrans = 2'h2;
          r_next.state = dctl_pkg::MST_ADDR;
        end
      end
      dctl_pkg::MST_ADDR: begin
        if (mHready) begin
          r_next.htrans = 2'h0;
          r_next.hwdata = r_reg.data;
          r_next.state = dctl_pkg::MST_DATA;
        end
      end
      dctl_pkg::MST_DATA: begin
        // no timeout: the slave decides how long the data phase lasts
        if (mHready) begin
          r_next.rdata = mHrdata;
          r_next.done = 1'b1;
          r_next.state = dctl_pkg::MST_IDLE;
        end
      end
      default: r_next.state = dctl_pkg::MST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign done = r_reg.done;
  assign rdata = r_reg.rdata;
  assign mHaddr = r_reg.haddr;
  assign mHtrans = r_reg.htrans;
  assign mHwrite = r_reg.hwrite;
  assign mHsize = 3'h2;
  assign mHwdata = r_reg.hwdata;

endmodule : dctl_ahb_mst

`default_nettype wire

// >>> src/dctl_wake_check.sv
`default_nettype none
`include "dctl_defs.svh"

module dctl_wake_check #(
  parameter int FSP_COUNT = `DCTL_FSPS
) (
  input wire logic [`DCTL_TIERS-1:0] enReq, // requested enables, bit 0 shallowest
  input wire logic [FSP_COUNT-1:0][`DCTL_TIERS*`DCTL_TIER_W-1:0] wake, // tiers per set point
  output logic [`DCTL_TIERS-1:0] enFilled, // enables with deeper states added
  output logic orderOk // tiers strictly rising in every set point
);

  if (FSP_COUNT < 1 || FSP_COUNT > `DCTL_FSPS) begin : g_bad
    $error("dctl_wake_check: FSP_COUNT out of range");
  end

  // -----------------------------------------------------------------
  // ordering per set point
  // -----------------------------------------------------------------
  function automatic logic tiersRising(input logic [`DCTL_TIERS*`DCTL_TIER_W-1:0] t);
    logic ok;
    ok = 1'b1;
    for (int i = 1; i < `DCTL_TIERS; i++) begin
      if (t[i*`DCTL_TIER_W +: `DCTL_TIER_W] <= t[(i-1)*`DCTL_TIER_W +: `DCTL_TIER_W]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : tiersRising

  logic [FSP_COUNT-1:0] fspOk;

  for (genvar f = 0; f < FSP_COUNT; f++) begin : g_fsp
    assign fspOk[f] = tiersRising(wake[f]);
  end

  assign orderOk = &fspOk;

  // -----------------------------------------------------------------
  // any enabled state pulls in every deeper one
  // -----------------------------------------------------------------
  for (genvar b = 0; b < `DCTL_TIERS; b++) begin : g_en
    assign enFilled[b] = |enReq[b:0];
  end

endmodule : dctl_wake_check

`default_nettype wire

// >>> verif/dctl_dev_model.sv
`default_nettype none
module dctl_dev_model (
  input wire logic mclk, // system clock
  input wire logic [31:0] mHaddr, // address
  input wire logic [1:0] mHtrans, // transfer type
  input wire logic mHwrite, // direction
  input wire logic [31:0] mHwdata, // write data
  input wire logic slow, // two wait states per transfer
  input wire logic failMode, // self-test disturbs one status word
  output logic mHready, // ready
  output logic [31:0] mHrdata // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [bit [31:0]];
  logic [31:0] pa;
  logic pw, pv;
  int wt, polls;
  // unwritten words other than 32'h494 read their inverted address with bit 3 clear, so a missed set shows
  function automatic logic [31:0] rd(input logic [31:0] a);
    if (a == 32'h494) begin
      polls++;
      return polls > 2 ? 32'h800 : 32'h0;
    end
    return mem.exists(a) ? mem[a] : ~a & 32'hffff_fff7;
  endfunction : rd
  initial begin
    mHready = 1'b1;
    mHrdata = 32'h0;
    pv = 1'b0;
    pw = 1'b0;
    pa = 32'h0;
    wt = 0;
    polls = 0;
  end
  always @(posedge mclk) begin
    if (pv && mHready) begin
      pv = 1'b0;
      if (pw && pa == 32'h308 && mHwdata[0]) begin
        mem[pa] = mHwdata & 32'hffff_fcff;
        polls = 0;
        if (failMode) begin
          mem[32'h4b8] = ~rd(32'h4b8);
        end
      end else if (pw) begin
        mem[pa] = mHwdata;
      end
    end
    // outside a valid read data phase the data lines keep toggling
    if (wt > 0) begin
      wt--;
      mHready <= wt == 0;
      mHrdata <= wt == 0 && !pw ? rd(pa) : ~mHrdata;
    end else if (mHready && mHtrans[1]) begin
      pa = mHaddr;
      pw = mHwrite;
      pv = 1'b1;
      wt = slow ? 2 : 0;
      mHready <= !slow;
      mHrdata <= !slow && !pw ? rd(pa) : ~mHrdata;
    end else begin
      mHrdata <= ~mHrdata;
    end
  end
endmodule : dctl_dev_model
`default_nettype wire

// >>> verif/dctl_host_monitor.sv
`default_nettype none
module dctl_host_monitor #(
  parameter int CS_COUNT = 4
) (
  input wire logic mclk, // clock
  input wire logic resetn, // sync reset, active low
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // slave response
  input wire logic [31:0] mHaddr, // device address
  input wire logic [1:0] mHtrans, // device transfer type
  input wire logic mHwrite, // device direction
  input wire logic [31:0] mHwdata, // device write data
  input wire logic mHready, // device ready
  input wire logic [31:0] mHrdata // device read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dv, dw, doneSeen, fin, ctlWr, lpWr, mrWr, snapRd;
  logic [31:0] da;
  logic [4:0] snapCnt;
  assign fin = dv && mHready;
  assign ctlWr = fin && dw && da == 32'h308;
  assign lpWr = fin && dw && da == 32'h22c;
  assign mrWr = fin && dw && da[2:0] == 3'h4 && da >= 32'h240c && da < 32'h240c + 8 * CS_COUNT;
  assign snapRd = fin && !dw && (da == 32'h338 || (da >= 32'h4b8 && da <= 32'h4dc));
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dv <= 1'b0;
      dw <= 1'b0;
      da <= 32'h0;
      doneSeen <= 1'b0;
      snapCnt <= 5'h0;
    end else begin
      if (mHready) begin
        dv <= mHtrans[1];
        dw <= mHwrite;
        da <= mHaddr;
      end
      if (ctlWr) begin
        snapCnt <= 5'h0;
        doneSeen <= 1'b0;
      end else if (snapRd) begin
        snapCnt <= snapCnt + 5'h1;
      end else if (fin && !dw && da == 32'h494 && mHrdata[11]) begin
        doneSeen <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_slave_ok;
    hreadyout && !hresp;
  endproperty
  a_slave_ok: assert property (p_slave_ok) else $error("slave stalled or erred");
  property p_wdata_hold;
    dv && dw && !mHready |=> $stable(mHwdata) && mHtrans == 2'h0;
  endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved in stall");
  property p_en_field;
    lpWr |-> !mHwdata[29];
  endproperty
  a_en_field: assert property (p_en_field) else $error("enable bit 29 set");
  property p_en_filled;
    lpWr |-> (mHwdata[27:24] & ~mHwdata[28:25]) == 4'h0;
  endproperty
  a_en_filled: assert property (p_en_filled) else $error("deeper state left off");
  property p_mr13_fast;
    mrWr |-> mHwdata[3];
  endproperty
  a_mr13_fast: assert property (p_mr13_fast) else $error("fast mode bit clear");
  property p_go_after_snap;
    ctlWr && mHwdata[0] |-> snapCnt == 5'd11;
  endproperty
  a_go_after_snap: assert property (p_go_after_snap) else $error("go before snapshot");
  property p_done_polled;
    ctlWr && !mHwdata[0] |-> doneSeen;
  endproperty
  a_done_polled: assert property (p_done_polled) else $error("stop before done");
  property p_reread;
    ctlWr && !mHwdata[0] |-> snapCnt == 5'd11;
  endproperty
  a_reread: assert property (p_reread) else $error("status words not re-read");
endmodule : dctl_host_monitor
bind dctl_host dctl_host_monitor #(.CS_COUNT(CS_COUNT)) u_dctl_host_monitor (
  .mclk(mclk), .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp), .mHaddr(mHaddr),
  .mHtrans(mHtrans), .mHwrite(mHwrite), .mHwdata(mHwdata), .mHready(mHready),
  .mHrdata(mHrdata));
`default_nettype wire

// >>> verif/tb_dctl_host.sv
`default_nettype none
`include "dctl_defs.svh"
module tb_dctl_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, resetn, hsel, hwrite, hready, hresp, irq, mHwrite, mHready, slow, failMode;
  logic [1:0] htrans, mHtrans;
  logic [2:0] hsize, mHsize;
  logic [31:0] haddr, hwdata, hrdata, mHaddr, mHwdata, mHrdata, rv, a;
  logic [31:0] bad [3] = '{32'h3c102081, 32'h03103081, 32'h3c103083};
  logic [4:0] en [3] = '{5'h01, 5'h10, 5'h0a};
  logic [5:0] fl [3] = '{6'h1f, 6'h10, 6'h1e};
  int badCount, numChecks;
  dctl_host #(.CS_COUNT(4)) u_dctl_host (
    .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .mHaddr(mHaddr), .mHtrans(mHtrans),
    .mHwrite(mHwrite), .mHsize(mHsize), .mHwdata(mHwdata), .mHready(mHready),
    .mHrdata(mHrdata), .mHresp(1'b0));
  dctl_dev_model u_dctl_dev_model (
    .mclk(mclk), .mHaddr(mHaddr), .mHtrans(mHtrans), .mHwrite(mHwrite), .mHwdata(mHwdata),
    .slow(slow), .failMode(failMode), .mHready(mHready), .mHrdata(mHrdata));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task endSim();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : endSim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rv = hrdata;
  endtask : xfer
  task wr(input logic [5:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask : wr
  task rdc(input logic [5:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rv, exp);
  endtask : rdc
  // polls the event register, bounded, so a lost event fails instead of hanging
  task waitEv();
    for (int i = 0; i < 200; i++) begin
      xfer(1'b0, `DCTL_REG_IRQ_STAT, 32'h0);
      if (rv !== 32'h0) break;
    end
  endtask : waitEv
  task clr(input logic [31:0] ev);
    wr(`DCTL_REG_IRQ_STAT, ev);
    rdc(`DCTL_REG_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : clr
  task bist(input logic [31:0] ev, input logic [31:0] st);
    wr(`DCTL_REG_BIST_CTL, 32'h100);
    wr(`DCTL_REG_CMD, 32'h1);
    waitEv();
    chk(rv, ev);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b0, `DCTL_REG_STATUS, 32'h0);
    chk(rv & 32'h3f0, st);
    chk(u_dctl_dev_model.mem[32'h308], 32'h100);
    clr(ev);
    $display("self-test case done");
  endtask : bist
  initial begin
    repeat (40000) @(posedge mclk);
    badCount++;
    endSim();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, slow, failMode, resetn} = 5'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    badCount = 0;
    numChecks = 0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 16; i++) rdc(6'(i), 32'h0);
    chk({29'h0, mHsize}, 32'h2);
    $display("reset values done");
    wr(`DCTL_REG_IRQ_MASK, 32'h1f);
    bist(32'h1, 32'h20);
    wr(`DCTL_REG_IRQ_MASK, 32'h0);
    wr(`DCTL_REG_LP_EN, 32'h04);
    for (int f = 0; f < 3; f++) begin
      for (int j = 0; j < 3; j++) wr(6'(`DCTL_REG_WAKE_F0 + j), j == f ? bad[f] : 32'h3c103081);
      wr(`DCTL_REG_CMD, 32'h2);
      waitEv();
      chk(rv, 32'h8);
      chk({31'h0, irq}, {31'h0, f != 0});
      wr(`DCTL_REG_IRQ_MASK, 32'h1f);
      clr(32'h8);
    end
    rdc(`DCTL_REG_IRQ_MASK, 32'h1f);
    $display("wake order refusal done");
    slow <= 1'b1;
    failMode <= 1'b1;
    bist(32'h3, 32'h40);
    failMode <= 1'b0;
    for (int j = 0; j < 3; j++) wr(6'(`DCTL_REG_WAKE_F0 + j), 32'h3c103081 + (j << 24));
    for (int k = 0; k < 3; k++) begin
      wr(`DCTL_REG_LP_EN, {27'h0, en[k]});
      wr(`DCTL_REG_CMD, 32'h2);
      waitEv();
      chk(rv, 32'h4);
      a = u_dctl_dev_model.mem[32'h22c];
      chk(a, 32'hc0ff_fdd3 | {2'h0, fl[k], 24'h0});
      for (int j = 0; j < 3; j++) begin
        chk(u_dctl_dev_model.mem[32'h4000 + 4 * j], 32'h3c103081 + (j << 24));
      end
      clr(32'h4);
    end
    $display("low-power setup done");
    wr(`DCTL_REG_CMD, 32'h4);
    waitEv();
    chk(rv, 32'h10);
    for (int cs = 0; cs < 4; cs++) begin
      a = 32'h240c + 8 * cs;
      chk(u_dctl_dev_model.mem[a], ~a | 32'h8);
    end
    clr(32'h10);
    $display("training setup done");
    endSim();
  end
endmodule : tb_dctl_host
`default_nettype wire
